// File: dsi_pkg.sv
`default_nettype none
package dsi_pkg;
    // Special function register addresses
    localparam logic [7:0] SYNC_IRQ_ADDR  = 8'hC8;
    localparam logic [7:0] SLICE_CTL_ADDR = 8'hCE;
    // Sync register field positions
    localparam int HS_FLAG_BIT  = 0;
    localparam int HS_EN_BIT    = 1;
    localparam int VS_FLAG_BIT  = 2;
    localparam int VS_EN_BIT    = 3;
    localparam int PCLK_BIT     = 4;
    localparam int HS_LVL_BIT   = 5;
    localparam int VS_LVL_BIT   = 6;
    // Slicer control field positions
    localparam int LOW_CODE_LSB  = 0;
    localparam int LOW_HYST_BIT  = 2;
    localparam int HIGH_CODE_LSB = 4;
    localparam int HIGH_HYST_BIT = 6;
    // Writable bits of the slicer register; bits 3 and 7 read zero
    localparam logic [7:0] SLICE_WMASK = 8'h77;
    localparam logic [7:0] SYNC_RESET  = 8'h00;
    localparam logic [7:0] SLICE_RESET = 8'h00;
    // Sandcastle digital filter length in clocks
    localparam int SC_FILTER_LEN = 4;
endpackage
`default_nettype wire

// File: dsi_sync_front.sv
`timescale 1ns/1ps
`default_nettype none
// Synchroniser, sandcastle filter/decoder and edge detection
module dsi_sync_front
    import dsi_pkg::*;
#(
    parameter int FILTER_LEN = SC_FILTER_LEN
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Sync sources
    input  wire logic combinedSyncPin,
    input  wire logic scLowSliced,
    input  wire logic scHighSliced,
    input  wire logic verticalSyncIn,
    input  wire logic combinedSyncSelect,
    // Results
    dsi_sync_if.src   sync
);
    localparam int CW = $clog2(FILTER_LEN + 1);

    logic [1:0] pinMeta;
    logic [1:0] pinSync;
    logic [1:0] scMeta;
    logic [1:0] scSync;
    logic [1:0] scFilt;
    logic [CW-1:0] lowCnt;
    logic [CW-1:0] highCnt;
    logic hsPrev;
    logic vsPrev;
    logic decHs;
    logic decVs;
    wire  lowStable  = lowCnt == CW'(FILTER_LEN);
    wire  highStable = highCnt == CW'(FILTER_LEN);

    // Two-stage synchronisers for pins and slicer outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinMeta <= 2'h0;
            pinSync <= 2'h0;
            scMeta  <= 2'h0;
            scSync  <= 2'h0;
        end else begin
            pinMeta <= {verticalSyncIn, combinedSyncPin}; // R16
            pinSync <= pinMeta;
            scMeta  <= {scHighSliced, scLowSliced};
            scSync  <= scMeta;
        end
    end

    // Digital filter: level must hold FILTER_LEN+1 clocks to pass spikes out
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lowCnt  <= '0;
            highCnt <= '0;
            scFilt  <= 2'h0;
        end else begin
            lowCnt  <= (scSync[0] == scFilt[0]) ? '0
                     : (lowStable ? '0 : lowCnt + CW'(1)); // R14
            highCnt <= (scSync[1] == scFilt[1]) ? '0
                     : (highStable ? '0 : highCnt + CW'(1)); // R14
            if (lowStable)
                scFilt[0] <= scSync[0];
            if (highStable)
                scFilt[1] <= scSync[1];
        end
    end

    // Above low slice only: horizontal; above high slice: vertical
    assign decHs = scFilt[0] & ~scFilt[1];
    assign decVs = scFilt[1];

    // Source select between sandcastle and separate pins
    assign sync.hsLevel = combinedSyncSelect ? decHs : pinSync[0]; // R15
    assign sync.vsLevel = combinedSyncSelect ? decVs : pinSync[1]; // R15

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hsPrev <= 1'b0;
            vsPrev <= 1'b0;
        end else begin
            hsPrev <= sync.hsLevel;
            vsPrev <= sync.vsLevel;
        end
    end

    // One pulse per rising edge
    assign sync.hsRise = sync.hsLevel & ~hsPrev; // R16
    assign sync.vsRise = sync.vsLevel & ~vsPrev; // R16
endmodule
`default_nettype wire

// File: dsi_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronised sync levels and their rising edges
interface dsi_sync_if;
    logic hsLevel;
    logic vsLevel;
    logic hsRise;
    logic vsRise;
    modport src (output hsLevel, output vsLevel, output hsRise, output vsRise);
    modport dst (input hsLevel, input vsLevel, input hsRise, input vsRise);
endinterface
`default_nettype wire

// File: dsi_sync_irq.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - HS rising edge sets sticky HS flag
// R2 - HS request forwarded only when enabled
// R3 - VS rising edge sets sticky VS flag
// R4 - VS request forwarded only when enabled
// R5 - Pixel clock level readable in status
// R6 - Decoded HS level readable in status
// R7 - VS status follows selected sync source
// R8 - Software writes zero to sync bit 7
// R9 - Two-bit code sets lower slice threshold
// R10 - Bit selects lower threshold hysteresis
// R11 - Two-bit code sets upper slice threshold
// R12 - Bit selects upper threshold hysteresis
// R13 - Software keeps slicer bits 3,7 zero
// R14 - Sliced sandcastle digitally filtered
// R15 - Select bit picks sandcastle or pins
// R16 - Inputs synchronised before edge detection
module dsi_sync_irq
    import dsi_pkg::*;
#(
    parameter int FILTER_LEN = SC_FILTER_LEN
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Special function register port
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrite,
    input  wire logic       sfrRead,
    input  wire logic [7:0] sfrWdata,
    output logic      [7:0] sfrRdata,
    output logic            sfrHit,
    // Sync inputs
    input  wire logic       combinedSyncPin,
    input  wire logic       verticalSyncIn,
    input  wire logic       scLowSliced,
    input  wire logic       scHighSliced,
    input  wire logic       combinedSyncSelect,
    input  wire logic       pixelClock,
    // Slicer settings to analog front end
    output logic      [1:0] lowSliceLevelCode,
    output logic            lowSliceHysteresis,
    output logic      [1:0] highSliceLevelCode,
    output logic            highSliceHysteresis,
    // Interrupt requests to processor
    output logic            hsyncIrq,
    output logic            vsyncIrq
);
    import dsi_pkg::*;

    dsi_sync_if syncBus ();

    logic       hsyncIrqFlag;
    logic       hsyncIrqEnable;
    logic       vsyncIrqFlag;
    logic       vsyncIrqEnable;
    logic [7:0] sliceCtl;
    logic [7:0] next_rdata;

    wire selSync  = sfrAddr == SYNC_IRQ_ADDR;
    wire selSlice = sfrAddr == SLICE_CTL_ADDR;
    wire wrSync   = sfrWrite & selSync;
    wire wrSlice  = sfrWrite & selSlice;

    dsi_sync_front #(
        .FILTER_LEN (FILTER_LEN)
    ) front (
        .clk                (clk),
        .resetn             (resetn),
        .combinedSyncPin    (combinedSyncPin),
        .scLowSliced        (scLowSliced),
        .scHighSliced       (scHighSliced),
        .verticalSyncIn     (verticalSyncIn),
        .combinedSyncSelect (combinedSyncSelect),
        .sync               (syncBus)
    );

    // Sticky flags; an edge in the clearing write cycle wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hsyncIrqFlag <= SYNC_RESET[HS_FLAG_BIT];
            vsyncIrqFlag <= SYNC_RESET[VS_FLAG_BIT];
        end else begin
            if (syncBus.hsRise)
                hsyncIrqFlag <= 1'b1; // R1
            else if (wrSync)
                hsyncIrqFlag <= sfrWdata[HS_FLAG_BIT]; // R1
            if (syncBus.vsRise)
                vsyncIrqFlag <= 1'b1; // R3
            else if (wrSync)
                vsyncIrqFlag <= sfrWdata[VS_FLAG_BIT]; // R3
        end
    end

    // Enables and slicer control; bit 7 of sync and 3/7 of slicer ignored
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hsyncIrqEnable <= SYNC_RESET[HS_EN_BIT];
            vsyncIrqEnable <= SYNC_RESET[VS_EN_BIT];
            sliceCtl       <= SLICE_RESET;
        end else begin
            if (wrSync) begin
                hsyncIrqEnable <= sfrWdata[HS_EN_BIT];
                vsyncIrqEnable <= sfrWdata[VS_EN_BIT];
            end
            if (wrSlice)
                sliceCtl <= sfrWdata & SLICE_WMASK; // R13
        end
    end

    // Slicer fields drive the analog thresholds
    assign lowSliceLevelCode   = sliceCtl[LOW_CODE_LSB +: 2]; // R9
    assign lowSliceHysteresis  = sliceCtl[LOW_HYST_BIT]; // R10
    assign highSliceLevelCode  = sliceCtl[HIGH_CODE_LSB +: 2]; // R11
    assign highSliceHysteresis = sliceCtl[HIGH_HYST_BIT]; // R12

    // Gated requests
    assign hsyncIrq = hsyncIrqFlag & hsyncIrqEnable; // R2
    assign vsyncIrq = vsyncIrqFlag & vsyncIrqEnable; // R4

    // Read mux; live levels sampled at read; bit 7 reads zero
    always_comb begin
        next_rdata = 8'h00;
        if (selSync) begin
            next_rdata[HS_FLAG_BIT] = hsyncIrqFlag;
            next_rdata[HS_EN_BIT]   = hsyncIrqEnable;
            next_rdata[VS_FLAG_BIT] = vsyncIrqFlag;
            next_rdata[VS_EN_BIT]   = vsyncIrqEnable;
            next_rdata[PCLK_BIT]    = pixelClock; // R5
            next_rdata[HS_LVL_BIT]  = syncBus.hsLevel; // R6
            next_rdata[VS_LVL_BIT]  = syncBus.vsLevel; // R7
        end else if (selSlice) begin
            next_rdata = sliceCtl;
        end
    end

    // Registered read data, updated on read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            sfrRdata <= 8'h00;
        else if (sfrRead)
            sfrRdata <= next_rdata;
    end

    assign sfrHit = selSync | selSlice;
endmodule
`default_nettype wire

// File: dsi_sync_irq_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the sync interrupt block
module dsi_sync_irq_sva
    import dsi_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] sfrAddr,
    input wire logic       sfrWrite,
    input wire logic       sfrRead,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    input wire logic       sfrHit,
    input wire logic [1:0] lowSliceLevelCode,
    input wire logic       lowSliceHysteresis,
    input wire logic [1:0] highSliceLevelCode,
    input wire logic       highSliceHysteresis,
    input wire logic       hsyncIrq,
    input wire logic       vsyncIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Decoded accesses and the slicer image as software reads it
    wire       wrSync  = sfrWrite && sfrAddr == SYNC_IRQ_ADDR;
    wire       wrSlice = sfrWrite && sfrAddr == SLICE_CTL_ADDR;
    wire       rdSlice = sfrRead && sfrAddr == SLICE_CTL_ADDR;
    wire [7:0] slice   = {1'b0, highSliceHysteresis, highSliceLevelCode,
                          1'b0, lowSliceHysteresis, lowSliceLevelCode};
    sequence s_slice_wr;
        wrSlice ##1 1'b1;
    endsequence
    a_low_field_wr: assert property (s_slice_wr |-> slice[2:0] == $past(sfrWdata[2:0])) else $error("low slicer field");
    a_high_field_wr: assert property (s_slice_wr |-> slice[6:4] == $past(sfrWdata[6:4])) else $error("high slicer field");
    a_slice_hold: assert property (!wrSlice |=> $stable(slice)) else $error("slicer changed");
    a_slice_read: assert property (rdSlice && !sfrWrite |=> sfrRdata == $past(slice)) else $error("slicer read");
    a_sync_bit7: assert property (sfrRead && sfrAddr == SYNC_IRQ_ADDR |=> !sfrRdata[7]) else $error("sync bit 7");
    a_unmapped_zero: assert property (sfrRead && !sfrHit |=> sfrRdata == 8'h00) else $error("unmapped read");
    a_hit_decode: assert property (sfrHit == (sfrAddr == SYNC_IRQ_ADDR || sfrAddr == SLICE_CTL_ADDR)) else $error("hit decode");
    a_read_hold: assert property (!sfrRead |=> $stable(sfrRdata)) else $error("read data moved");
    a_hs_sticky: assert property ($fell(hsyncIrq) |-> $past(wrSync)) else $error("hs request lost");
    a_vs_sticky: assert property ($fell(vsyncIrq) |-> $past(wrSync)) else $error("vs request lost");
endmodule
`default_nettype wire

// File: dsi_sync_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dsi_sync_irq_tb;
    import dsi_pkg::*;
    logic       clk, resetn, sfrWrite, sfrRead, combinedSyncSelect, pixelClock;
    logic [7:0] sfrAddr, sfrWdata;
    wire  logic [7:0] sfrRdata, slice;
    wire  logic [1:0] lowSliceLevelCode, highSliceLevelCode;
    wire  logic sfrHit, lowSliceHysteresis, highSliceHysteresis, hsyncIrq, vsyncIrq;
    wire  logic combinedSyncPin, verticalSyncIn, scLowSliced, scHighSliced;
    int         errCount, checked;
    assign slice = {1'b0, highSliceHysteresis, highSliceLevelCode,
                    1'b0, lowSliceHysteresis, lowSliceLevelCode};
    dsi_sync_irq #(.FILTER_LEN(2)) i_dut (.*);
    dsi_sync_src i_src (.*);
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        checked++;
        if (s !== e) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = 1'b1;
        @(negedge clk);
        sfrWrite = 1'b0;
    endtask
    // Read data is registered, so it is judged one cycle after the strobe
    task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] mk);
        @(negedge clk);
        sfrAddr = a;
        sfrRead = 1'b1;
        @(negedge clk);
        sfrRead = 1'b0;
        chk("rdata", sfrRdata & mk, e & mk);
    endtask
    // Every slicer code with alternating hysteresis; bits 3 and 7 kept zero
    task automatic t_slice();
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = {1'b0, i[0], i[1:0], 1'b0, !i[0], ~i[1:0]};
            wr(SLICE_CTL_ADDR, d);
            chk("slice", slice, d);
            rd(SLICE_CTL_ADDR, d, 8'hFF);
        end
    endtask
    // Edge sets one sticky request; irq gated by enable; live levels readable
    task automatic t_sync(logic [3:0] m, logic sc, logic v);
        logic [7:0] en, fl, lv, mk;
        en = v ? 8'h08 : 8'h02;
        fl = v ? 8'h04 : 8'h01;
        lv = v ? 8'h40 : (sc ? 8'h20 : 8'h00);
        mk = sc ? 8'hFF : 8'hDF; // HS level bit follows combinedSyncPin on pins; not checked
        combinedSyncSelect = sc;
        tick(10);
        wr(SYNC_IRQ_ADDR, en);
        i_src.drive(m);
        tick(8);
        chk("irq", {7'h0, v ? vsyncIrq : hsyncIrq}, 8'h01);
        rd(SYNC_IRQ_ADDR, en | fl | lv | 8'h10, mk);
        i_src.drive(4'h0);
        tick(8);
        wr(SYNC_IRQ_ADDR, en);
        tick(2);
        chk("irq", {7'h0, v ? vsyncIrq : hsyncIrq}, 8'h00);
        rd(SYNC_IRQ_ADDR, en | 8'h10, mk);
        wr(SYNC_IRQ_ADDR, 8'h00);
        i_src.drive(m);
        tick(8);
        chk("irq", {7'h0, v ? vsyncIrq : hsyncIrq}, 8'h00);
        i_src.drive(4'h0);
        tick(8);
        rd(SYNC_IRQ_ADDR, fl | 8'h10, mk);
    endtask
    // One-cycle sandcastle spike must not reach the decoder
    task automatic t_spike();
        wr(SYNC_IRQ_ADDR, 8'h0A);
        i_src.drive(4'h3);
        i_src.drive(4'h0);
        tick(10);
        rd(SYNC_IRQ_ADDR, 8'h1A, 8'hFF);
    endtask
    task automatic printVerdict();
        $display("mismatches %0d of %0d checks", errCount, checked);
        if (errCount == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        printVerdict();
    end
    // Main sequence, reset held for 12 cycles
    initial begin
        {resetn, sfrWrite, sfrRead, combinedSyncSelect, pixelClock} = 5'h0;
        {sfrAddr, sfrWdata} = 16'h0000;
        tick(12);
        resetn = 1'b1;
        rd(SYNC_IRQ_ADDR, SYNC_RESET, 8'hFF);
        rd(SLICE_CTL_ADDR, SLICE_RESET, 8'hFF);
        rd(8'h55, 8'h00, 8'hFF);
        t_slice();
        pixelClock = 1'b1;
        t_sync(4'h8, 1'b0, 1'b0);
        t_sync(4'h4, 1'b0, 1'b1);
        t_sync(4'h2, 1'b1, 1'b0);
        t_sync(4'h3, 1'b1, 1'b1);
        t_spike();
        printVerdict();
    end
endmodule
bind dsi_sync_irq dsi_sync_irq_sva i_sva (.*);
`default_nettype wire

// File: dsi_sync_src.sv
`timescale 1ns/1ps
`default_nettype none
// Video sync source: separate pins plus sliced sandcastle comparators
module dsi_sync_src (
    // Clock
    input  wire logic clk,
    // Sync lines, idle low
    output var  logic combinedSyncPin,
    output var  logic verticalSyncIn,
    output var  logic scLowSliced,
    output var  logic scHighSliced
);
    initial begin
        {combinedSyncPin, verticalSyncIn, scLowSliced, scHighSliced} = 4'h0;
    end
    // Levels change just after a falling edge; low only = line, both = field
    task automatic drive(input logic [3:0] v);
        @(negedge clk);
        {combinedSyncPin, verticalSyncIn, scLowSliced, scHighSliced} = v;
    endtask
endmodule
`default_nettype wire
